// File: hw/dcrf_control_regs.sv
// control register file of the dsp core with indirect flag updates and direct enable writes
module dcrf_control_regs #(
   parameter logic [7:0] CPU_ID = 8'h00,
   parameter logic [7:0] REVISION_ID = 8'h00,
   parameter logic LITTLE_ENDIAN = 1'b1
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic mvcValid,
   input wire logic mvcWrite,
   input wire logic [dcrf_pkg::CADDR_W-1:0] mvcAddr,
   input wire logic [dcrf_pkg::DATA_W-1:0] mvcWrData,
   output logic [dcrf_pkg::DATA_W-1:0] mvcRdData,
   output logic mvcRdValid,
   input wire logic [dcrf_pkg::DATA_W-1:0] exec_phase_pc,
   input wire logic [dcrf_pkg::IRQ_HI:dcrf_pkg::IRQ_LO] extIrqPin,
   input wire logic irqTaken,
   input wire logic [3:0] irqTakenNum,
   input wire logic branchIrp,
   input wire logic branchNrp,
   input wire logic satResultWr,
   input wire logic ptrCalcValid,
   input wire logic [2:0] ptrSel,
   input wire logic [dcrf_pkg::DATA_W-1:0] ptrBase,
   input wire logic [dcrf_pkg::DATA_W-1:0] ptrOffset,
   output logic [dcrf_pkg::DATA_W-1:0] ptrResult,
   output logic ptrResultValid,
   output logic globalIrqEnable,
   output logic nonmaskIrqEnable,
   output logic clipFlag,
   output logic [dcrf_pkg::IRQ_HI:dcrf_pkg::IRQ_LO] irqFlags,
   output logic [dcrf_pkg::IRQ_HI:dcrf_pkg::IRQ_LO] irqEnables,
   output logic [dcrf_pkg::DATA_W-1:0] vectorTablePtr
);
   import dcrf_pkg::*;

   if (IRQ_HI >= DATA_W || IRQ_LO < 2) begin : gIrqCheck
      $error("dcrf_control_regs: interrupt range does not fit the registers");
   end

   typedef struct packed {
      logic [AMR_USED_W-1:0] addr_mode_reg;
      logic [5:0] pwrd;
      logic clip_flag;
      logic [2:0] pcc;
      logic [2:0] dcc;
      logic pgie;
      logic global_irq_enable;
      logic [IRQ_HI:IRQ_LO] irq_flag_reg;
      logic [IRQ_HI:IRQ_LO] irq_enable_reg;
      logic nonmask_irq_enable;
      logic [DATA_W-1:0] vector_table_ptr;
      logic [DATA_W-1:0] irq_return_ptr;
      logic [DATA_W-1:0] nmi_return_ptr;
      logic [IRQ_HI:IRQ_LO] pendSet;
      logic [IRQ_HI:IRQ_LO] pendClr;
      logic satPend;
      logic [IRQ_HI:IRQ_LO] pinS1;
      logic [IRQ_HI:IRQ_LO] pinS2;
      logic [IRQ_HI:IRQ_LO] pinS3;
      logic [IRQ_HI:IRQ_LO] pinLvl;
      logic [DATA_W-1:0] rdData;
      logic rdValid;
   } dcrf_state_t;

   dcrf_state_t state_reg;
   dcrf_state_t state_next;
   logic [1:0] rstSync_reg;
   logic rstN;
   logic [MODE_W-1:0] ptrMode;

   // reset is released through two flops so every state flop leaves reset together
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rstSync_reg <= 2'h0;
      end else begin
         rstSync_reg <= {rstSync_reg[0], 1'b1};
      end
   end
   assign rstN = rstSync_reg[1];

   function automatic logic [DATA_W-1:0] csrView(input dcrf_state_t s);
      csrView = '0;
      csrView[CSR_CPUID_LSB +: 8] = CPU_ID;
      csrView[CSR_REV_LSB +: 8] = REVISION_ID;
      csrView[CSR_PWRD_LSB +: 6] = s.pwrd;
      csrView[CSR_SAT_BIT] = s.clip_flag;
      csrView[CSR_EN_BIT] = LITTLE_ENDIAN;
      csrView[CSR_PCC_LSB +: 3] = s.pcc;
      csrView[CSR_DCC_LSB +: 3] = s.dcc;
      csrView[CSR_PGIE_BIT] = s.pgie;
      csrView[CSR_GIE_BIT] = s.global_irq_enable;
   endfunction : csrView

   always_comb begin
      logic rd;
      logic wr;
      logic [IRQ_HI:IRQ_LO] edgeSet;
      logic [IRQ_HI:IRQ_LO] takenClr;
      logic [IRQ_HI:IRQ_LO] lvlNext;
      rd = mvcValid && !mvcWrite;
      wr = mvcValid && mvcWrite;
      state_next = state_reg;

      // pin synchroniser: a change counts once the second and third stages agree
      state_next.pinS1 = extIrqPin;
      state_next.pinS2 = state_reg.pinS1;
      state_next.pinS3 = state_reg.pinS2;
      lvlNext = state_reg.pinLvl;
      for (int i = IRQ_LO; i <= IRQ_HI; i++) begin
         if (state_reg.pinS2[i] == state_reg.pinS3[i]) begin
            lvlNext[i] = state_reg.pinS3[i];
         end
      end
      state_next.pinLvl = lvlNext;
      edgeSet = lvlNext & ~state_reg.pinLvl;

      takenClr = '0;
      if (irqTaken && irqTakenNum >= 4'(IRQ_LO)) begin
         takenClr[irqTakenNum] = 1'b1;
      end

      // flag update: pending writes land one clock after the move, sets win over clears
      state_next.irq_flag_reg = (state_reg.irq_flag_reg & ~state_reg.pendClr & ~takenClr)
         | state_reg.pendSet | edgeSet;
      state_next.pendSet = '0;
      state_next.pendClr = '0;

      // clip flag: events delayed one clock, then set beats any clear
      state_next.satPend = satResultWr;

      state_next.rdValid = rd;
      if (rd) begin
         case (mvcAddr)
            ADDR_AMR: state_next.rdData = {{(DATA_W - AMR_USED_W){1'b0}}, state_reg.addr_mode_reg};
            ADDR_CSR: state_next.rdData = csrView(state_reg);
            ADDR_IFR_ISR: state_next.rdData = DATA_W'({state_reg.irq_flag_reg, {IRQ_LO{1'b0}}});
            ADDR_IER: state_next.rdData = DATA_W'({state_reg.irq_enable_reg, 2'b00, state_reg.nonmask_irq_enable,
               1'b1});
            ADDR_VECTOR_TABLE_PTR: state_next.rdData = state_reg.vector_table_ptr;
            ADDR_IRP: state_next.rdData = state_reg.irq_return_ptr;
            ADDR_NRP: state_next.rdData = state_reg.nmi_return_ptr;
            ADDR_PCE: state_next.rdData = exec_phase_pc;
            default: state_next.rdData = '0;
         endcase
      end

      if (wr) begin
         case (mvcAddr)
            ADDR_AMR: state_next.addr_mode_reg = mvcWrData[AMR_USED_W-1:0];
            ADDR_CSR: begin
               state_next.pwrd = mvcWrData[CSR_PWRD_LSB +: 6];
               // the clip flag can only be cleared by a move
               state_next.clip_flag = state_reg.clip_flag & mvcWrData[CSR_SAT_BIT];
               state_next.pcc = mvcWrData[CSR_PCC_LSB +: 3];
               state_next.dcc = mvcWrData[CSR_DCC_LSB +: 3];
               state_next.pgie = mvcWrData[CSR_PGIE_BIT];
               state_next.global_irq_enable = mvcWrData[CSR_GIE_BIT];
            end
            ADDR_IFR_ISR: state_next.pendSet = mvcWrData[IRQ_HI:IRQ_LO];
            // a pin edge on the same bit in the clock the clear lands cancels the clear
            ADDR_ICR: state_next.pendClr = mvcWrData[IRQ_HI:IRQ_LO];
            ADDR_IER: begin
               state_next.irq_enable_reg = mvcWrData[IRQ_HI:IRQ_LO];
               state_next.nonmask_irq_enable = mvcWrData[IER_NONMASK_IRQ_ENABLE_BIT];
            end
            ADDR_VECTOR_TABLE_PTR: state_next.vector_table_ptr = mvcWrData;
            ADDR_IRP: state_next.irq_return_ptr = mvcWrData;
            ADDR_NRP: state_next.nmi_return_ptr = mvcWrData;
            default: ;
         endcase
      end

      if (state_reg.satPend) begin
         state_next.clip_flag = 1'b1;
      end

      // interrupt entry saves the enable; return branch restores it at once
      if (irqTaken) begin
         state_next.pgie = state_reg.global_irq_enable;
         state_next.global_irq_enable = 1'b0;
      end else if (branchIrp) begin
         state_next.global_irq_enable = state_reg.pgie;
      end
      if (branchNrp) begin
         state_next.nonmask_irq_enable = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         state_reg <= '0;
         state_reg.addr_mode_reg <= AMR_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

   // mode field of the selected pointer, A4-A7 then B4-B7
   assign ptrMode = state_reg.addr_mode_reg[ptrSel * MODE_W +: MODE_W];

   dcrf_circ_addr #(
      .ADDR_W(DATA_W)
   ) uCircAddr (
      .clk(clk),
      .rstN(rstN),
      .calcValid(ptrCalcValid),
      .mode(ptrMode),
      .bk0(state_reg.addr_mode_reg[AMR_BK0_LSB +: BK_W]),
      .bk1(state_reg.addr_mode_reg[AMR_BK1_LSB +: BK_W]),
      .baseAddr(ptrBase),
      .offsetVal(ptrOffset),
      .resultAddr(ptrResult),
      .resultValid(ptrResultValid)
   );

   assign mvcRdData = state_reg.rdData;
   assign mvcRdValid = state_reg.rdValid;
   assign globalIrqEnable = state_reg.global_irq_enable;
   assign nonmaskIrqEnable = state_reg.nonmask_irq_enable;
   assign clipFlag = state_reg.clip_flag;
   assign irqFlags = state_reg.irq_flag_reg;
   assign irqEnables = state_reg.irq_enable_reg;
   assign vectorTablePtr = state_reg.vector_table_ptr;
endmodule : dcrf_control_regs

// File: hw/dcrf_pkg.sv
// constants shared by the control register file and its address unit
package dcrf_pkg;
   localparam int DATA_W = 32;
   localparam int CADDR_W = 5;

   // control register addresses
   localparam logic [4:0] ADDR_AMR = 5'h00;
   localparam logic [4:0] ADDR_CSR = 5'h01;
   localparam logic [4:0] ADDR_IFR_ISR = 5'h02;
   localparam logic [4:0] ADDR_ICR = 5'h03;
   localparam logic [4:0] ADDR_IER = 5'h04;
   localparam logic [4:0] ADDR_VECTOR_TABLE_PTR = 5'h05;
   localparam logic [4:0] ADDR_IRP = 5'h06;
   localparam logic [4:0] ADDR_NRP = 5'h07;
   localparam logic [4:0] ADDR_PCE = 5'h10;

   // addressing mode register layout
   localparam int AMR_USED_W = 26;
   localparam int AMR_BK1_LSB = 21;
   localparam int AMR_BK0_LSB = 16;
   localparam int BK_W = 5;
   localparam int MODE_W = 2;
   localparam int NUM_PTR = 8;
   localparam logic [25:0] AMR_RESET = 26'h0000000;
   localparam logic [1:0] MODE_LINEAR = 2'h0;
   localparam logic [1:0] MODE_CIRC_BK0 = 2'h1;
   localparam logic [1:0] MODE_CIRC_BK1 = 2'h2;
   localparam logic [4:0] BK_AS_LINEAR = 5'h1F;

   // control status register layout
   localparam int CSR_CPUID_LSB = 24;
   localparam int CSR_REV_LSB = 16;
   localparam int CSR_PWRD_LSB = 10;
   localparam int CSR_SAT_BIT = 9;
   localparam int CSR_EN_BIT = 8;
   localparam int CSR_PCC_LSB = 5;
   localparam int CSR_DCC_LSB = 2;
   localparam int CSR_PGIE_BIT = 1;
   localparam int CSR_GIE_BIT = 0;

   // interrupt registers
   localparam int IRQ_LO = 4;
   localparam int IRQ_HI = 15;
   localparam int IER_NONMASK_IRQ_ENABLE_BIT = 1;
   localparam int IER_RESET_BIT = 0;
endpackage : dcrf_pkg

// File: hw/dcrf_circ_addr.sv
// pointer update unit: linear or circular modification of an address register
module dcrf_circ_addr #(
   parameter int ADDR_W = 32
) (
   input wire logic clk,
   input wire logic rstN,
   input wire logic calcValid,
   input wire logic [dcrf_pkg::MODE_W-1:0] mode,
   input wire logic [dcrf_pkg::BK_W-1:0] bk0,
   input wire logic [dcrf_pkg::BK_W-1:0] bk1,
   input wire logic [ADDR_W-1:0] baseAddr,
   input wire logic [ADDR_W-1:0] offsetVal,
   output logic [ADDR_W-1:0] resultAddr,
   output logic resultValid
);
   import dcrf_pkg::*;

   if (ADDR_W != DATA_W) begin : gWidthCheck
      $error("dcrf_circ_addr: ADDR_W must equal the data width");
   end

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic valid;
   } dcrf_circ_state_t;

   dcrf_circ_state_t state_reg;
   dcrf_circ_state_t state_next;

   // mask of the bits that move inside a 2^(n+1) byte block
   function automatic logic [ADDR_W-1:0] blockMask(input logic [BK_W-1:0] n);
      logic [ADDR_W:0] span;
      span = '0;
      if (n == BK_AS_LINEAR) begin
         blockMask = '1;
      end else begin
         span[n + 5'h01] = 1'b1;
         blockMask = ADDR_W'(span - 1'b1);
      end
   endfunction : blockMask

   always_comb begin
      logic [ADDR_W-1:0] sum;
      logic [ADDR_W-1:0] mask;
      mask = '1;
      sum = baseAddr + offsetVal;
      state_next = state_reg;
      state_next.valid = calcValid;
      case (mode)
         MODE_CIRC_BK0: mask = blockMask(bk0);
         MODE_CIRC_BK1: mask = blockMask(bk1);
         default: mask = '1;
      endcase
      if (calcValid) begin
         // upper bits held so the pointer stays inside its aligned block
         state_next.addr = (baseAddr & ~mask) | (sum & mask);
      end
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign resultAddr = state_reg.addr;
   assign resultValid = state_reg.valid;
endmodule : dcrf_circ_addr

// File: verification/dcrf_asserts.sv
// assertions on the ports of the control register file
module dcrf_asserts (
   input wire logic clk,
   input wire logic nrst,
   input wire logic mvcValid,
   input wire logic mvcWrite,
   input wire logic [dcrf_pkg::CADDR_W-1:0] mvcAddr,
   input wire logic [dcrf_pkg::DATA_W-1:0] mvcWrData,
   input wire logic mvcRdValid,
   input wire logic [dcrf_pkg::IRQ_HI:dcrf_pkg::IRQ_LO] extIrqPin,
   input wire logic irqTaken,
   input wire logic branchIrp,
   input wire logic branchNrp,
   input wire logic satResultWr,
   input wire logic ptrCalcValid,
   input wire logic ptrResultValid,
   input wire logic globalIrqEnable,
   input wire logic nonmaskIrqEnable,
   input wire logic clipFlag,
   input wire logic [dcrf_pkg::IRQ_HI:dcrf_pkg::IRQ_LO] irqFlags
);
   timeunit 1ns;
   timeprecision 1ps;
   import dcrf_pkg::*;
   default clocking @(posedge clk);
   endclocking
   default disable iff (!nrst);
   sequence s_rd; mvcValid && !mvcWrite; endsequence
   // pins quiet long enough that no filtered edge is still in flight
   sequence s_quiet; (extIrqPin == '0) [*8]; endsequence
   sequence s_isr;
      globalIrqEnable && irqTaken && !mvcValid ##1 branchIrp && !irqTaken && !mvcValid;
   endsequence
   property p_rd_lat; s_rd |=> mvcRdValid; endproperty
   property p_rd_cause; mvcRdValid |-> $past(mvcValid && !mvcWrite); endproperty
   property p_set;
      mvcValid && mvcWrite && mvcAddr == ADDR_IFR_ISR
         |-> ##2 (irqFlags & $past(mvcWrData[15:4], 2)) == $past(mvcWrData[15:4], 2);
   endproperty
   property p_clr;
      s_quiet ##0 (mvcValid && mvcWrite && mvcAddr == ADDR_ICR)
         |-> ##2 (irqFlags & $past(mvcWrData[15:4], 2)) == '0;
   endproperty
   property p_take; irqTaken && !mvcValid |=> !globalIrqEnable; endproperty
   property p_ret; s_isr |=> globalIrqEnable; endproperty
   property p_nmi; branchNrp && !mvcValid |=> nonmaskIrqEnable; endproperty
   property p_clip; satResultWr |-> ##2 clipFlag; endproperty
   property p_clip_cause; $rose(clipFlag) |-> $past(satResultWr, 2); endproperty
   property p_ptr; ptrCalcValid |=> ptrResultValid; endproperty
   a_rd_lat: assert property (p_rd_lat) else $error("read answer missing");
   a_rd_cause: assert property (p_rd_cause) else $error("read answer unasked");
   a_set: assert property (p_set) else $error("flag set late");
   a_clr: assert property (p_clr) else $error("flag clear late");
   a_take: assert property (p_take) else $error("enable kept on take");
   a_ret: assert property (p_ret) else $error("enable not restored");
   a_nmi: assert property (p_nmi) else $error("nmi enable late");
   a_clip: assert property (p_clip) else $error("clip flag late");
   a_clip_cause: assert property (p_clip_cause) else $error("clip flag early");
   a_ptr: assert property (p_ptr) else $error("pointer answer missing");
endmodule : dcrf_asserts

// File: verification/dcrf_pipe_model.sv
// pipeline side model issuing move_control accesses
module dcrf_pipe_model (
   input wire logic clk,
   input wire logic [dcrf_pkg::DATA_W-1:0] mvcRdData,
   output logic mvcValid,
   output logic mvcWrite,
   output logic [dcrf_pkg::CADDR_W-1:0] mvcAddr,
   output logic [dcrf_pkg::DATA_W-1:0] mvcWrData
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      {mvcValid, mvcWrite, mvcAddr, mvcWrData} = '0;
   end
   // the only path into the registers; valid is held for back-to-back use
   task automatic xfer(input logic w, input logic [4:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      mvcValid = 1'h1;
      mvcWrite = w;
      mvcAddr = a;
      mvcWrData = d;
      @(posedge clk);
      #1;
      q = mvcRdData;
   endtask : xfer
   // released data never keeps its last value
   task automatic idle();
      mvcValid = 1'h0;
      mvcWrData = ~mvcWrData;
   endtask : idle
endmodule : dcrf_pipe_model

// File: verification/testbench.sv
// self-checking bench for the control register file
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import dcrf_pkg::*;
   logic clk, nrst, mvcValid, mvcWrite, mvcRdValid, irqTaken, branchIrp, branchNrp;
   logic satResultWr, ptrCalcValid, ptrResultValid, globalIrqEnable, nonmaskIrqEnable, clipFlag;
   logic [4:0] mvcAddr;
   logic [3:0] irqTakenNum;
   logic [2:0] ptrSel;
   logic [1:0] m;
   logic [31:0] mvcWrData, mvcRdData, exec_phase_pc, ptrBase, ptrOffset, ptrResult, vectorTablePtr, q, d;
   logic [15:4] extIrqPin, irqFlags, irqEnables;
   int errors, compares;
   dcrf_control_regs i_dcrf_control_regs (.*);
   dcrf_pipe_model i_dcrf_pipe_model (.*);
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic rd(input logic [4:0] a, input logic [31:0] exp);
      i_dcrf_pipe_model.xfer(1'h0, a, 32'h0, q);
      chk(q, exp);
   endtask : rd
   task automatic wr(input logic [4:0] a, input logic [31:0] v);
      i_dcrf_pipe_model.xfer(1'h1, a, v, q);
   endtask : wr
   task automatic cyc(input int n);
      i_dcrf_pipe_model.idle();
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc
   function automatic logic [31:0] nxt(logic [31:0] b, o, logic [1:0] md, logic [4:0] k0, k1);
      logic [4:0] n;
      logic [31:0] k;
      n = md[1] ? k1 : k0;
      k = (32'h2 << n) - 32'h1;
      if (md == 2'h0 || md == 2'h3 || n == 5'h1F) return b + o;
      return (b & ~k) | ((b + o) & k);
   endfunction : nxt
   task automatic close_out();
      $display("errors=%0d compares=%0d", errors, compares);
      if (errors == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : close_out
   initial begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end
   // the tests need well under two thousand cycles
   initial begin
      #20000;
      errors++;
      close_out();
   end
   initial begin
      {nrst, irqTaken, branchIrp, branchNrp, satResultWr, ptrCalcValid} = '0;
      {irqTakenNum, ptrSel, extIrqPin, ptrBase, ptrOffset} = '0;
      errors = 0;
      compares = 0;
      exec_phase_pc = $urandom(95555);
      cyc(8);
      nrst = 1'h1;
      cyc(3);
      rd(ADDR_AMR, 32'h0);
      rd(ADDR_CSR, 32'h100);
      rd(ADDR_IER, 32'h1);
      rd(ADDR_ICR, 32'h0);
      rd(5'h1F, 32'h0);
      wr(ADDR_PCE, ~exec_phase_pc);
      rd(ADDR_PCE, exec_phase_pc);
      $display("test reset done");
      repeat (8) begin
         d = $urandom;
         wr(ADDR_AMR, d);
         rd(ADDR_AMR, d & 32'h03FFFFFF);
         for (int a = 5; a < 8; a++) begin
            wr(a[4:0], d);
            rd(a[4:0], d);
         end
         chk(vectorTablePtr, d);
         wr(ADDR_IER, d);
         rd(ADDR_IER, (d & 32'hFFF2) | 32'h1);
         chk(32'(irqEnables), (d >> 4) & 32'hFFF);
      end
      $display("test round trip done");
      d = ($urandom & 32'hFFF0) | 32'h30;
      wr(ADDR_IFR_ISR, d);
      rd(ADDR_IFR_ISR, 32'h0);
      rd(ADDR_IFR_ISR, d);
      wr(ADDR_ICR, 32'h30);
      rd(ADDR_IFR_ISR, d);
      rd(ADDR_IFR_ISR, d & 32'hFFCF);
      wr(ADDR_ICR, 32'hFFFF);
      wr(ADDR_CSR, 32'h1);
      $display("test flag pair done");
      extIrqPin[7] = 1'h1;
      cyc(8);
      rd(ADDR_IFR_ISR, 32'h80);
      cyc(1);
      irqTakenNum = 4'h7;
      irqTaken = 1'h1;
      cyc(1);
      irqTaken = 1'h0;
      chk(32'(globalIrqEnable), 32'h0);
      branchIrp = 1'h1;
      cyc(1);
      branchIrp = 1'h0;
      chk(32'(globalIrqEnable), 32'h1);
      rd(ADDR_IFR_ISR, 32'h0);
      rd(ADDR_CSR, 32'h103);
      cyc(1);
      branchNrp = 1'h1;
      cyc(1);
      branchNrp = 1'h0;
      chk(32'(nonmaskIrqEnable), 32'h1);
      extIrqPin = '0;
      satResultWr = 1'h1;
      cyc(1);
      satResultWr = 1'h0;
      chk(32'(clipFlag), 32'h0);
      cyc(1);
      chk(32'(clipFlag), 32'h1);
      wr(ADDR_CSR, 32'h1);
      rd(ADDR_CSR, 32'h101);
      $display("test events done");
      repeat (6) begin
         d = $urandom % 31;
         wr(ADDR_AMR, {6'h0, 5'h1F, d[4:0], 16'h0039});
         cyc(1);
         ptrCalcValid = 1'h1;
         for (int s = 0; s < 8; s++) begin
            m = 2'(16'h0039 >> (2 * s));
            ptrSel = s[2:0];
            ptrBase = $urandom;
            ptrOffset = $urandom & 32'h3F;
            cyc(1);
            chk(ptrResult, nxt(ptrBase, ptrOffset, m, d[4:0], 5'h1F));
         end
         ptrCalcValid = 1'h0;
      end
      $display("test pointer done");
      close_out();
   end
endmodule : testbench
bind dcrf_control_regs dcrf_asserts i_dcrf_asserts (.*);
